// ---- srw_top.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Reset asserts on supply low, manual reset low, or watchdog expiry.
// - After any source releases, reset stays asserted for the full hold period.
// - Dual variant drives complementary outputs; single variant drives only active-low.
// - An undriven manual reset input counts as high.
// - Manual reset is debounced so a push-button gives one clean event.
// - Manual reset lows up to 100 ns are ignored.
// - Every strobe edge, rising or falling, clears the watchdog counter.
// - Strobe pulses of 50 ns are recognised as valid edges.
// - Watchdog reaching its timeout asserts reset with a full pulse.
// - Supply-low or manual reset also clears the watchdog counter.
// - Watchdog stays cleared while reset is asserted; counts only after release.
// - A floating strobe input disables the watchdog entirely.
module srw_top
	import srw_pkg::*;
#(
	parameter longint HOLD_CYC   = HOLD_CYC_DFLT,
	parameter longint WD_CYC     = WD_CYC_DFLT,
	parameter bit     HAS_WDOG   = 1'b1,
	parameter bit     HAS_MANUAL = 1'b1,
	parameter bit     HAS_DUAL   = 1'b0
)
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_supply_low,
	input  wire logic       i_manual_reset_n,
	input  wire logic       i_manual_reset_driven,
	input  wire logic       i_watchdog_strobe_in,
	input  wire logic       i_watchdog_strobe_driven,
	output logic            o_reset_n,
	output logic            o_reset,
	output logic [1:0]      o_reset_cause
);

	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 64'd1);
	localparam logic [CNT_W-1:0] WD_LAST   = CNT_W'(WD_CYC - 64'd1);

	// ------------------------------------------------------------------
	// Input conditioning
	// ------------------------------------------------------------------
	logic supply_s;
	logic man_s;
	logic man_f;
	logic man_drv_s;
	logic strobe_f;
	logic wd_en_s;

	srw_input_cond #(.FILT_CYC(LEVEL_FILT_CYC), .RST_LVL(LOW_RST_LVL)) u_supply (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_raw     (i_supply_low),
		.o_sync    (supply_s),
		.o_filt    ()
	);

	// Filter rejects short lows and settles bounce into one level change
	srw_input_cond #(.FILT_CYC(MAN_FILT_CYC), .RST_LVL(MAN_RST_LVL)) u_manual (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_raw     (i_manual_reset_n),
		.o_sync    (man_s),
		.o_filt    (man_f)
	);

	// Each pin is synchronised alone; gating two raw pins could glitch
	srw_input_cond #(.FILT_CYC(LEVEL_FILT_CYC), .RST_LVL(MAN_RST_LVL)) u_manual_drv (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_raw     (i_manual_reset_driven),
		.o_sync    (man_drv_s),
		.o_filt    ()
	);

	srw_input_cond #(.FILT_CYC(STROBE_FILT_CYC), .RST_LVL(LOW_RST_LVL)) u_strobe (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_raw     (i_watchdog_strobe_in),
		.o_sync    (),
		.o_filt    (strobe_f)
	);

	srw_input_cond #(.FILT_CYC(LEVEL_FILT_CYC), .RST_LVL(LOW_RST_LVL)) u_strobe_drv (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_raw     (i_watchdog_strobe_driven),
		.o_sync    (wd_en_s),
		.o_filt    ()
	);

	// ------------------------------------------------------------------
	// Source decoding
	// ------------------------------------------------------------------
	logic                strobe_prev_q;
	srw_state_e          state_q;
	srw_state_e          state_d;
	logic [CNT_W-1:0]    hold_cnt_q;
	logic [CNT_W-1:0]    hold_cnt_d;
	logic [CNT_W-1:0]    wd_cnt_q;
	logic [CNT_W-1:0]    wd_cnt_d;
	logic [1:0]          cause_q;
	logic [1:0]          cause_d;
	logic                reset_n_q;
	logic                reset_hi_q;

	// An undriven pin sits on its pull-up; a driver that takes over while
	// the filtered level is still low is seen as a press
	wire manual_low   = HAS_MANUAL & ~man_f & man_drv_s;
	wire level_src    = supply_s | manual_low;
	// Both edge directions clear the counter; a 50 ns pulse spans five samples
	wire strobe_edge  = strobe_f ^ strobe_prev_q;
	wire wd_enabled   = HAS_WDOG & wd_en_s;
	wire wd_at_limit  = wd_cnt_q == WD_LAST;
	wire wd_expire    = (state_q == ST_RUN) & wd_enabled & wd_at_limit
		& ~strobe_edge;
	wire hold_done    = hold_cnt_q == HOLD_LAST;
	wire reset_next   = state_d != ST_RUN;
	wire [1:0] level_cause = supply_s ? CAUSE_SUPPLY : CAUSE_MANUAL;

	// ------------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------------
	always_comb
	begin
		state_d    = state_q;
		hold_cnt_d = '0;
		cause_d    = cause_q;
		case (state_q)
			ST_ACTIVE:
			begin
				if (!level_src)
					state_d = ST_HOLD;
			end
			ST_HOLD:
			begin
				if (level_src)
				begin
					state_d = ST_ACTIVE;
					cause_d = level_cause;
				end
				else if (hold_done)
					state_d = ST_RUN;
				else
					hold_cnt_d = hold_cnt_q + CNT_W'(1);
			end
			ST_RUN:
			begin
				if (level_src)
				begin
					state_d = ST_ACTIVE;
					cause_d = level_cause;
				end
				else if (wd_expire)
				begin
					// Expiry has no level to wait on, so go straight to hold
					state_d = ST_HOLD;
					cause_d = CAUSE_WATCHDOG;
				end
			end
			default:
			begin
				state_d = ST_ACTIVE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Watchdog counter
	// ------------------------------------------------------------------
	// Held clear while reset is out, on any edge, or when disabled; this
	// also covers clearing on supply-low and manual reset entry
	always_comb
	begin
		if (state_q != ST_RUN || level_src || strobe_edge || !wd_enabled)
			wd_cnt_d = '0;
		else if (wd_at_limit)
			wd_cnt_d = '0;
		else
			wd_cnt_d = wd_cnt_q + CNT_W'(1);
	end

	// ------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------
	// Start in reset so power-up also sees a full hold period
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_q       <= ST_ACTIVE;
			hold_cnt_q    <= '0;
			wd_cnt_q      <= '0;
			strobe_prev_q <= LOW_RST_LVL;
			cause_q       <= CAUSE_NONE;
		end
		else
		begin
			state_q       <= state_d;
			hold_cnt_q    <= hold_cnt_d;
			wd_cnt_q      <= wd_cnt_d;
			strobe_prev_q <= strobe_f;
			cause_q       <= cause_d;
		end
	end

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			reset_n_q  <= 1'b0;
			reset_hi_q <= HAS_DUAL;
		end
		else
		begin
			reset_n_q  <= ~reset_next;
			reset_hi_q <= HAS_DUAL & reset_next;
		end
	end

	assign o_reset_n     = reset_n_q;
	assign o_reset       = reset_hi_q;
	assign o_reset_cause = cause_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	property p_supply_asserts;
		supply_s |=> !o_reset_n;
	endproperty
	a_supply_asserts: assert property (p_supply_asserts)
		else $error("Supply low did not assert reset");

	property p_manual_asserts;
		manual_low |=> (!o_reset_n && o_reset_cause != CAUSE_NONE);
	endproperty
	a_manual_asserts: assert property (p_manual_asserts)
		else $error("Manual reset low did not assert reset");

	property p_hold_full;
		$rose(o_reset_n) |-> ($past(hold_cnt_q) == HOLD_LAST && $past(state_q) == ST_HOLD);
	endproperty
	a_hold_full: assert property (p_hold_full)
		else $error("Reset released before the full hold period");

	property p_hold_stays;
		(state_q == ST_HOLD && !hold_done) |=> !o_reset_n;
	endproperty
	a_hold_stays: assert property (p_hold_stays)
		else $error("Reset released during hold period");

	property p_complement;
		HAS_DUAL |-> (o_reset == !o_reset_n);
	endproperty
	a_complement: assert property (p_complement)
		else $error("Dual reset outputs are not complements");

	property p_single_quiet;
		!HAS_DUAL |-> !o_reset;
	endproperty
	a_single_quiet: assert property (p_single_quiet)
		else $error("Single variant drove the active-high reset");

	property p_glitch_ignored;
		$fell(man_f) |-> ($past(man_s, 1) == 1'b0 && $past(man_s, MAN_FILT_CYC) == 1'b0);
	endproperty
	a_glitch_ignored: assert property (p_glitch_ignored)
		else $error("Manual reset accepted a short low");

	property p_edge_clears;
		(strobe_edge && state_q == ST_RUN) |=> (wd_cnt_q == '0);
	endproperty
	a_edge_clears: assert property (p_edge_clears)
		else $error("Strobe edge did not clear the watchdog");

	property p_expire_resets;
		(wd_expire && !level_src) |=> (!o_reset_n && state_q == ST_HOLD
			&& hold_cnt_q == '0 && o_reset_cause == CAUSE_WATCHDOG);
	endproperty
	a_expire_resets: assert property (p_expire_resets)
		else $error("Watchdog expiry did not start a full reset pulse");

	property p_wd_held_clear;
		!o_reset_n |-> (wd_cnt_q == '0);
	endproperty
	a_wd_held_clear: assert property (p_wd_held_clear)
		else $error("Watchdog counted while reset was asserted");

	property p_wd_disabled;
		(!wd_enabled && state_q == ST_RUN && !level_src)
			|=> (state_q == ST_RUN && wd_cnt_q == '0);
	endproperty
	a_wd_disabled: assert property (p_wd_disabled)
		else $error("Disabled watchdog kept counting");

	property p_wd_runs;
		(state_q == ST_RUN && !reset_next && wd_enabled && !strobe_edge && !wd_at_limit)
			|=> (wd_cnt_q == $past(wd_cnt_q) + CNT_W'(1));
	endproperty
	a_wd_runs: assert property (p_wd_runs)
		else $error("Watchdog did not advance while released");

endmodule

// ---- srw_pkg.sv ----
package srw_pkg;

	// ------------------------------------------------------------------
	// Timebase
	// ------------------------------------------------------------------
	localparam longint CLK_PERIOD_NS = 64'd10;

	// ------------------------------------------------------------------
	// Documented times, in their own units
	// ------------------------------------------------------------------
	localparam longint HOLD_PERIOD_MS   = 64'd140;
	localparam longint WD_TIMEOUT_MS    = 64'd1600;
	localparam longint MAN_GLITCH_NS    = 64'd100;
	localparam longint STROBE_PULSE_NS  = 64'd50;
	localparam longint NS_PER_MS        = 64'd1000000;

	// ------------------------------------------------------------------
	// Derived cycle counts
	// ------------------------------------------------------------------
	// Least hold time rounds up
	localparam longint HOLD_CYC_DFLT =
		(HOLD_PERIOD_MS * NS_PER_MS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam longint WD_CYC_DFLT = (WD_TIMEOUT_MS * NS_PER_MS) / CLK_PERIOD_NS;
	// Longest ignored glitch rounds down
	localparam int unsigned MAN_GLITCH_CYC = int'(MAN_GLITCH_NS / CLK_PERIOD_NS);
	localparam int unsigned MAN_FILT_CYC   = MAN_GLITCH_CYC + 1;
	localparam int unsigned STROBE_MIN_CYC = int'(STROBE_PULSE_NS / CLK_PERIOD_NS);
	localparam int unsigned STROBE_FILT_CYC = 1;
	localparam int unsigned LEVEL_FILT_CYC  = 1;

	// ------------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------------
	localparam int unsigned CNT_W  = 32;
	localparam int unsigned FILT_W = 8;
	localparam logic        MAN_RST_LVL    = 1'b1;
	localparam logic        LOW_RST_LVL    = 1'b0;

	// ------------------------------------------------------------------
	// Reset cause codes
	// ------------------------------------------------------------------
	localparam logic [1:0] CAUSE_NONE     = 2'h0;
	localparam logic [1:0] CAUSE_SUPPLY   = 2'h1;
	localparam logic [1:0] CAUSE_MANUAL   = 2'h2;
	localparam logic [1:0] CAUSE_WATCHDOG = 2'h3;

	typedef enum logic [1:0] {
		ST_ACTIVE,
		ST_HOLD,
		ST_RUN
	} srw_state_e;

endpackage

// ---- srw_input_cond.sv ----
`timescale 1ns/1ns
module srw_input_cond
	import srw_pkg::*;
#(
	parameter int unsigned FILT_CYC = 1,
	parameter logic        RST_LVL  = 1'b0
)
(
	input  wire logic i_sys_clk,
	input  wire logic i_rstn,
	input  wire logic i_raw,
	output logic      o_sync,
	output logic      o_filt
);

	logic              meta_q;
	logic              sync_q;
	logic              filt_q;
	logic [FILT_W-1:0] cnt_q;
	logic [FILT_W-1:0] cnt_d;
	logic              filt_d;
	wire               differs  = sync_q != filt_q;
	wire               settled  = cnt_q == FILT_W'(FILT_CYC - 1);

	// ------------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_q <= RST_LVL;
			sync_q <= RST_LVL;
		end
		else
		begin
			meta_q <= i_raw;
			sync_q <= meta_q;
		end
	end

	// ------------------------------------------------------------------
	// Stability filter: level must differ for FILT_CYC cycles
	// ------------------------------------------------------------------
	always_comb
	begin
		cnt_d  = '0;
		filt_d = filt_q;
		if (differs)
		begin
			if (settled)
				filt_d = sync_q;
			else
				cnt_d = cnt_q + FILT_W'(1);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cnt_q  <= '0;
			filt_q <= RST_LVL;
		end
		else
		begin
			cnt_q  <= cnt_d;
			filt_q <= filt_d;
		end
	end

	assign o_sync = sync_q;
	assign o_filt = filt_q;

endmodule

// ---- srw_proc_model.sv ----
`timescale 1ns/1ns
module srw_proc_model
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset_n,
	input  wire logic [1:0] i_mode,
	input  wire logic [7:0] i_period,
	output logic            o_strobe,
	output logic            o_strobe_driven
);
	// ------------------------------------------------------------------
	// Strobe service loop
	// ------------------------------------------------------------------
	// Modes: 0 serviced, 1 stuck in subroutine, 2 pin released
	logic [7:0] cnt_q = 8'h00;

	always @(posedge i_sys_clk)
	begin
		if (i_mode == 2'h2)
		begin
			// A released pin with no pull shows the opposite of its last driven
			// level and then stands still, so it never services the watchdog
			if (o_strobe_driven)
				o_strobe <= ~o_strobe;
			o_strobe_driven <= 1'b0;
		end
		else if (!i_reset_n || i_mode == 2'h1)
		begin
			o_strobe_driven <= 1'b1;
			o_strobe        <= 1'b0;
			cnt_q           <= 8'h00;
		end
		else
		begin
			o_strobe_driven <= 1'b1;
			// Brief high of 5 cycles, low for the rest of the period
			o_strobe <= (cnt_q < 8'h05);
			cnt_q    <= (cnt_q >= i_period) ? 8'h00 : cnt_q + 8'h01;
		end
	end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb
	import srw_pkg::*;
;
	// ------------------------------------------------------------------
	// Environment
	// ------------------------------------------------------------------
	// Short counts keep the run brief; the hold and watchdog bounds below derive from them
	localparam int HOLD = 20;
	localparam int WDC  = 50;

	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        supply_low = 1'b0;
	logic        man_n = 1'b1;
	logic        man_drv = 1'b1;
	logic [1:0]  mode = 2'h0;
	logic [7:0]  period = 8'h1E;
	logic [31:0] seed = 32'hA63A9FDD;
	wire         strobe;
	wire         strobe_drv;
	wire         reset_n;
	wire         reset_hi;
	wire  [1:0]  cause;
	int          err_count = 0;
	int          total_checks = 0;
	int          falls = 0;
	int          n;
	int          f0;
	int          bounce [7] = '{3, 2, 4, 3, 100, 3, 2};

	always #5 sys_clk = ~sys_clk;

	srw_top #(.HOLD_CYC(HOLD), .WD_CYC(WDC), .HAS_DUAL(1'b1)) dut
	(
		.i_sys_clk                (sys_clk),
		.i_rstn                   (rstn),
		.i_supply_low             (supply_low),
		.i_manual_reset_n         (man_n),
		.i_manual_reset_driven    (man_drv),
		.i_watchdog_strobe_in     (strobe),
		.i_watchdog_strobe_driven (strobe_drv),
		.o_reset_n                (reset_n),
		.o_reset                  (reset_hi),
		.o_reset_cause            (cause)
	);

	srw_proc_model proc
	(
		.i_sys_clk       (sys_clk),
		.i_reset_n       (reset_n),
		.i_mode          (mode),
		.i_period        (period),
		.o_strobe        (strobe),
		.o_strobe_driven (strobe_drv)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'hB4BCD35C) : (s >> 1);
	endfunction

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic check_rng(input string name, input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi)
		begin
			err_count++;
			$display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	// Counts falling edges until the active-low reset shows val, up to limit
	task automatic wait_rst(input logic val, input int limit, output int cnt);
		cnt = 0;
		while (reset_n !== val && cnt < limit)
		begin
			@(negedge sys_clk);
			cnt++;
		end
	endtask

	task automatic close_out();
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(negedge reset_n) falls++;

	always @(negedge sys_clk)
		if (rstn === 1'b1)
			check("reset_pair", {31'h0, ~reset_n}, {31'h0, reset_hi});

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		close_out();
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic power_up();
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		check("reset_in_rst", 32'h0, {31'h0, reset_n});
		check("reset_hi_in_rst", 32'h1, {31'h0, reset_hi});
		check("cause_in_rst", {30'h0, CAUSE_NONE}, {30'h0, cause});
		@(posedge sys_clk);
		rstn <= 1'b1;
		wait_rst(1'b1, 200, n);
		check_rng("powerup_hold", HOLD, HOLD + 4, n);
	endtask

	initial
	begin
		power_up();
		// Serviced strobe at random periods never resets
		repeat (3)
		begin
			seed = lfsr(seed);
			@(posedge sys_clk);
			period <= 8'(10 + seed % 31);
			wait_rst(1'b0, 300, n);
			check("serviced", 300, n);
		end
		// Stuck subroutine: expiry, full hold, then a fresh count from release
		@(posedge sys_clk);
		mode <= 2'h1;
		wait_rst(1'b0, WDC + 10, n);
		check_rng("wd_expire", 1, WDC + 8, n);
		check("wd_cause", {30'h0, CAUSE_WATCHDOG}, {30'h0, cause});
		wait_rst(1'b1, 200, n);
		check_rng("wd_hold", HOLD, HOLD + 2, n);
		wait_rst(1'b0, 200, n);
		check_rng("wd_restart", WDC, WDC + 2, n);
		// Supply low in mid-count clears it; the next expiry counts from release
		wait_rst(1'b1, 200, n);
		repeat (20) @(posedge sys_clk);
		supply_low <= 1'b1;
		wait_rst(1'b0, 10, n);
		check_rng("sup_fall", 3, 5, n);
		repeat (8) @(negedge sys_clk);
		check("sup_cause", {30'h0, CAUSE_SUPPLY}, {30'h0, cause});
		wait_rst(1'b1, 60, n);
		check("sup_stay", 60, n);
		@(posedge sys_clk);
		supply_low <= 1'b0;
		wait_rst(1'b1, 200, n);
		check_rng("sup_hold", HOLD + 1, HOLD + 6, n);
		wait_rst(1'b0, 200, n);
		check_rng("sup_wd_fresh", WDC, WDC + 2, n);
		// Released strobe pin stands still: no expiry at all
		@(posedge sys_clk);
		mode <= 2'h2;
		wait_rst(1'b1, 200, n);
		wait_rst(1'b0, 3 * WDC, n);
		check("float_strobe", 3 * WDC, n);
		@(posedge sys_clk);
		mode <= 2'h0;
		// Undriven manual pin reads high whatever the wire shows
		@(posedge sys_clk);
		man_drv <= 1'b0;
		man_n <= 1'b0;
		wait_rst(1'b0, 100, n);
		check("float_manual", 100, n);
		// The released wire settles high before a driver takes it back over
		@(posedge sys_clk);
		man_n <= 1'b1;
		repeat (16) @(posedge sys_clk);
		man_drv <= 1'b1;
		// Short lows up to 100 ns are ignored
		f0 = falls;
		repeat (8)
		begin
			seed = lfsr(seed);
			@(posedge sys_clk);
			man_n <= 1'b0;
			repeat (1 + seed % 10) @(posedge sys_clk);
			man_n <= 1'b1;
			repeat (20) @(posedge sys_clk);
		end
		// Longest low that must still be ignored
		man_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		man_n <= 1'b1;
		repeat (20) @(posedge sys_clk);
		check("glitch_falls", f0, falls);
		// Bouncing press held past 1 us, bouncing release: one reset event
		f0 = falls;
		for (int i = 0; i < 7; i++)
		begin
			@(posedge sys_clk);
			man_n <= i[0];
			repeat (bounce[i] - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		man_n <= 1'b1;
		check("man_cause", {30'h0, CAUSE_MANUAL}, {30'h0, cause});
		wait_rst(1'b1, 200, n);
		check_rng("man_hold", HOLD + 11, HOLD + 17, n);
		check("man_falls", f0 + 1, falls);
		// Second reset in mid-run
		power_up();
		close_out();
	end
endmodule
